/* File: rtl/cfg_loader.sv */
// Configuration decoder: watchdog period, protection, user and identity words
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cfg_loader
    import cfg_pkg::*;
#(
    parameter logic [13:0] PART_ID  = 14'h1234, // Arbitrary value
    parameter logic [13:0] STEP_ID  = 14'h0001, // Arbitrary value
    parameter int          PM_DEPTH = 64
)(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Register port
    input  wire logic [CFG_AW-1:0]     reg_addr,
    input  wire logic [CFG_DW-1:0]     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [CFG_DW-1:0]          reg_rdata,
    // External programmer memory port
    input  wire logic                  ext_wr,
    input  wire logic                  ext_rd,
    input  wire logic [12:0]           ext_addr,
    input  wire logic [CFG_DW-1:0]     ext_wdata,
    output logic [CFG_DW-1:0]          ext_rdata,
    // CPU program memory port
    input  wire logic                  cpu_wr,
    input  wire logic                  cpu_rd,
    input  wire logic [12:0]           cpu_addr,
    input  wire logic [CFG_DW-1:0]     cpu_wdata,
    output logic [CFG_DW-1:0]          cpu_rdata,
    // Watchdog settings
    output logic [4:0]                 watchdog_prescale_setting,
    output logic [4:0]                 watchdog_ratio_log2,
    output logic                       watchdog_sw_locked,
    output logic [2:0]                 watchdog_window
);
    import cfg_pkg::*;

    localparam int PM_AW = $clog2(PM_DEPTH);

    logic [CFG_DW-1:0] conf1_reg, conf2_reg, conf3_reg;
    logic [CFG_DW-1:0] uid_reg [0:3];
    logic [CFG_DW-1:0] pmem [0:PM_DEPTH-1];
    logic [4:0]        wdt_ps_reg;
    logic [2:0]        wdt_win_reg;
    logic              por_load_reg;
    logic [CFG_DW-1:0] reg_rdata_reg, ext_rdata_reg, cpu_rdata_reg;

    // Decoded fields
    wire [4:0] psel      = conf3_reg[CFG_PSEL_LSB +: CFG_PSEL_W];
    wire       prot_n    = conf1_reg[CFG_CPN_BIT];
    wire [1:0] guard_sz  = conf2_reg[CFG_GUARD_LSB +: CFG_GUARD_W];
    wire [4:0] por_ps;
    wire       sw_ok;
    wire       ext_rd_ok, ext_wr_ok, cpu_rd_ok, cpu_wr_ok;

    cfg_period_decode u_dec (
        .watchdog_period_select (psel),
        .por_prescale           (por_ps),
        .ratio_log2             (watchdog_ratio_log2),
        .sw_control_ok          (sw_ok)
    );

    cfg_prog_guard u_ext_guard (
        .code_protect_n        (prot_n),
        .self_write_guard_size (guard_sz),
        .ext_access            (1'b1),
        .cpu_write             (1'b0),
        .addr                  (ext_addr),
        .read_allowed          (ext_rd_ok),
        .write_allowed         (ext_wr_ok)
    );

    cfg_prog_guard u_cpu_guard (
        .code_protect_n        (prot_n),
        .self_write_guard_size (guard_sz),
        .ext_access            (1'b0),
        .cpu_write             (cpu_wr),
        .addr                  (cpu_addr),
        .read_allowed          (cpu_rd_ok),
        .write_allowed         (cpu_wr_ok)
    );

    // Address decode
    wire hit_uid   = (reg_addr >= CFG_ADDR_UID0) && (reg_addr <= CFG_ADDR_UID3);
    wire [1:0] uid_idx = reg_addr[1:0];
    wire hit_conf1 = (reg_addr == CFG_ADDR_CONF1);
    wire hit_conf2 = (reg_addr == CFG_ADDR_CONF2);
    wire hit_conf3 = (reg_addr == CFG_ADDR_CONF3);
    wire hit_ps    = (reg_addr == CFG_ADDR_WDT_PS);
    wire hit_win   = (reg_addr == CFG_ADDR_WDT_WIN);

    // Configuration words take register writes; reset loads the erased value
    always_ff @(posedge clk) begin
        if (rst) begin
            conf1_reg <= CFG_CONF_ERASED;
            conf2_reg <= CFG_CONF_ERASED;
            conf3_reg <= CFG_CONF_ERASED;
        end else if (reg_wr) begin
            if (hit_conf1) conf1_reg <= reg_wdata;
            if (hit_conf2) conf2_reg <= reg_wdata;
            if (hit_conf3) conf3_reg <= reg_wdata;
        end
    end

    // User ID words
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_uid
            always_ff @(posedge clk) begin
                if (rst) begin
                    uid_reg[gi] <= CFG_UID_RESET;
                end else if (reg_wr && hit_uid && uid_idx == 2'(gi)) begin
                    uid_reg[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Load at reset release so the fuse value is sampled after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            por_load_reg <= 1'b1;
        end else begin
            por_load_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_ps_reg <= CFG_PSEL_SW_DEF;
        end else if (por_load_reg) begin
            wdt_ps_reg <= por_ps;
        end else if (reg_wr && hit_ps && sw_ok) begin
            wdt_ps_reg <= reg_wdata[4:0];
        end
    end

    // Window: fuse codes never yield 12.5 percent; software may
    wire [2:0] fuse_win = conf3_reg[8 +: CFG_WIN_W];
    wire [2:0] fuse_win_eff = (fuse_win == CFG_WIN_12P5) ? CFG_WIN_FULL : fuse_win;
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_win_reg <= CFG_WIN_FULL;
        end else if (por_load_reg) begin
            wdt_win_reg <= fuse_win_eff;
        end else if (reg_wr && hit_win) begin
            wdt_win_reg <= reg_wdata[2:0];
        end
    end

    // Program memory; external writes win when both hit one cycle
    wire ext_we = ext_wr && ext_wr_ok;
    wire cpu_we = cpu_wr && cpu_wr_ok;
    always_ff @(posedge clk) begin
        if (ext_we) begin
            pmem[ext_addr[PM_AW-1:0]] <= ext_wdata;
        end else if (cpu_we) begin
            pmem[cpu_addr[PM_AW-1:0]] <= cpu_wdata;
        end
    end

    // Read data for the register port; identity words are constants
    wire [CFG_DW-1:0] rd_mux =
        hit_uid                      ? uid_reg[uid_idx] :
        (reg_addr == CFG_ADDR_STEP)  ? STEP_ID :
        (reg_addr == CFG_ADDR_PART)  ? PART_ID :
        hit_conf1                    ? conf1_reg :
        hit_conf2                    ? conf2_reg :
        hit_conf3                    ? conf3_reg :
        hit_ps                       ? {9'h000, wdt_ps_reg} :
        hit_win                      ? {11'h000, wdt_win_reg} : 14'h0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_reg <= 14'h0000;
        end else begin
            reg_rdata_reg <= reg_rd ? rd_mux : 14'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_rdata_reg <= 14'h0000;
            cpu_rdata_reg <= 14'h0000;
        end else begin
            ext_rdata_reg <= (ext_rd && ext_rd_ok) ? pmem[ext_addr[PM_AW-1:0]] : 14'h0000;
            cpu_rdata_reg <= (cpu_rd && cpu_rd_ok) ? pmem[cpu_addr[PM_AW-1:0]] : 14'h0000;
        end
    end

    assign reg_rdata                 = reg_rdata_reg;
    assign ext_rdata                 = ext_rdata_reg;
    assign cpu_rdata                 = cpu_rdata_reg;
    assign watchdog_prescale_setting = wdt_ps_reg;
    assign watchdog_sw_locked        = !sw_ok;
    assign watchdog_window           = wdt_win_reg;
endmodule
`default_nettype wire

/* File: rtl/cfg_pkg.sv */
// Package: constants, field layouts and carriers for the configuration decoder
package cfg_pkg;

    localparam int CFG_AW = 16;
    localparam int CFG_DW = 14;

    // Word addresses in the configuration space
    localparam logic [15:0] CFG_ADDR_UID0    = 16'h8000;
    localparam logic [15:0] CFG_ADDR_UID3    = 16'h8003;
    localparam logic [15:0] CFG_ADDR_STEP    = 16'h8005;
    localparam logic [15:0] CFG_ADDR_PART    = 16'h8006;
    localparam logic [15:0] CFG_ADDR_CONF1   = 16'h8007;
    localparam logic [15:0] CFG_ADDR_CONF2   = 16'h8008;
    localparam logic [15:0] CFG_ADDR_CONF3   = 16'h8009;
    localparam logic [15:0] CFG_ADDR_WDT_PS  = 16'h8010;
    localparam logic [15:0] CFG_ADDR_WDT_WIN = 16'h8011;

    // Field positions
    localparam int CFG_PSEL_LSB = 0;
    localparam int CFG_PSEL_W   = 5;
    localparam int CFG_CPN_BIT  = 7;
    localparam int CFG_GUARD_LSB = 0;
    localparam int CFG_GUARD_W   = 2;
    localparam int CFG_WIN_W    = 3;

    // Period select encodings
    localparam logic [4:0] CFG_PSEL_ERASED  = 5'h1F;
    localparam logic [4:0] CFG_PSEL_SW_DEF  = 5'h0B;
    localparam logic [4:0] CFG_PSEL_MAXLOG  = 5'h12;
    localparam logic [4:0] CFG_PSEL_LOGBASE = 5'h05;
    localparam logic [4:0] CFG_PSEL_MINLOG  = 5'h05;

    // Window select codes
    localparam logic [2:0] CFG_WIN_12P5 = 3'h0;
    localparam logic [2:0] CFG_WIN_FULL = 3'h7;

    // Reset / erased values
    localparam logic [13:0] CFG_CONF_ERASED = 14'h3FFF;
    localparam logic [13:0] CFG_UID_RESET   = 14'h3FFF;

    // Guard size encodings for an 8K-word array
    localparam logic [1:0] CFG_GUARD_OFF  = 2'h3;
    localparam logic [1:0] CFG_GUARD_BOOT = 2'h2;
    localparam logic [1:0] CFG_GUARD_HALF = 2'h1;
    localparam logic [12:0] CFG_BOOT_TOP = 13'h01FF;
    localparam logic [12:0] CFG_HALF_TOP = 13'h0FFF;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [CFG_AW-1:0]     addr;
        logic [CFG_DW-1:0]     wdata;
    } cfg_req_t;

    typedef struct packed {
        logic                  we;
        logic                  re;
        logic [12:0]           addr;
        logic [CFG_DW-1:0]     wdata;
    } cfg_mem_req_t;

endpackage

/* File: rtl/cfg_period_decode.sv */
// Watchdog period select decoder: power-on prescale value and lock
`timescale 1ns/100ps
`default_nettype none
module cfg_period_decode
    import cfg_pkg::*;
(
    // Configuration field
    input  wire logic [4:0] watchdog_period_select,
    // Decoded result
    output logic [4:0]      por_prescale,
    output logic [4:0]      ratio_log2,
    output logic            sw_control_ok
);
    wire is_erased = (watchdog_period_select == CFG_PSEL_ERASED);
    wire is_fixed32 = (watchdog_period_select > CFG_PSEL_MAXLOG) && !is_erased;

    assign sw_control_ok = is_erased;
    assign por_prescale  = is_erased ? CFG_PSEL_SW_DEF : watchdog_period_select;
    // Divide ratio as a power of two
    // Largest sum is 17h, so five bits never overflow
    assign ratio_log2 = is_erased  ? 5'(CFG_PSEL_SW_DEF + CFG_PSEL_LOGBASE) :
                        is_fixed32 ? CFG_PSEL_MINLOG :
                        5'(watchdog_period_select + CFG_PSEL_LOGBASE);
endmodule
`default_nettype wire

/* File: rtl/cfg_prog_guard.sv */
// Program memory access guard: code protect and self-write guard size
`timescale 1ns/100ps
`default_nettype none
module cfg_prog_guard
    import cfg_pkg::*;
(
    // Protection settings
    input  wire logic        code_protect_n,
    input  wire logic [1:0]  self_write_guard_size,
    // Requests
    input  wire logic        ext_access,
    input  wire logic        cpu_write,
    input  wire logic [12:0] addr,
    // Decisions
    output logic             read_allowed,
    output logic             write_allowed
);
    wire in_guard = (self_write_guard_size == CFG_GUARD_BOOT) ? (addr <= CFG_BOOT_TOP) :
                    (self_write_guard_size == CFG_GUARD_HALF) ? (addr <= CFG_HALF_TOP) :
                    (self_write_guard_size == CFG_GUARD_OFF)  ? 1'b0 : 1'b1;

    // CPU reads never gated; protect bit only acts on external side
    assign read_allowed  = !ext_access || code_protect_n;
    assign write_allowed = ext_access ? code_protect_n
                         : (cpu_write && !in_guard);
endmodule
`default_nettype wire

/* File: tb/cfg_loader_assertions.sv */
// Port checker for the configuration decoder, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module cfg_loader_chk
    import cfg_pkg::*;
#(
    parameter logic [13:0] PART_ID = 14'h1234,
    parameter logic [13:0] STEP_ID = 14'h0001
)(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Register port
    input wire logic [CFG_AW-1:0] reg_addr,
    input wire logic [CFG_DW-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [CFG_DW-1:0] reg_rdata,
    // Programmer read path
    input wire logic              ext_rd,
    input wire logic [CFG_DW-1:0] ext_rdata,
    // Watchdog settings
    input wire logic [4:0]        watchdog_prescale_setting,
    input wire logic [4:0]        watchdog_ratio_log2,
    input wire logic              watchdog_sw_locked,
    input wire logic [2:0]        watchdog_window
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Protect bit shadowed from register writes; the bus is the only way in
    logic cpn_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            cpn_reg <= 1'b1;
        end else if (reg_wr && reg_addr == CFG_ADDR_CONF1) begin
            cpn_reg <= reg_wdata[CFG_CPN_BIT];
        end
    end
    AST_LOAD_AFTER_RESET: assert property (
        $fell(rst) |=> watchdog_prescale_setting == CFG_PSEL_SW_DEF)
        else $error("prescale not loaded from erased word");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside answer cycle");
    AST_PART_READ: assert property (
        reg_rd && reg_addr == CFG_ADDR_PART |=> reg_rdata == PART_ID)
        else $error("part identity read wrong");
    AST_STEP_READ: assert property (
        reg_rd && reg_addr == CFG_ADDR_STEP |=> reg_rdata == STEP_ID)
        else $error("revision read wrong");
    AST_FREE_RATIO: assert property (!watchdog_sw_locked |-> watchdog_ratio_log2 == 5'h10)
        else $error("erased code ratio wrong");
    AST_RATIO_RANGE: assert property (watchdog_ratio_log2 inside {[5'h05:5'h17]})
        else $error("ratio out of range");
    AST_LOCKED_HOLD: assert property (
        reg_wr && reg_addr == CFG_ADDR_WDT_PS && watchdog_sw_locked
        |=> $stable(watchdog_prescale_setting))
        else $error("locked prescale changed");
    AST_FREE_WRITE: assert property (
        reg_wr && reg_addr == CFG_ADDR_WDT_PS && !watchdog_sw_locked
        |=> watchdog_prescale_setting == $past(reg_wdata[4:0]))
        else $error("free prescale write lost");
    AST_PROTECT_READ: assert property (ext_rd && !cpn_reg |=> ext_rdata == '0)
        else $error("protected read leaked data");
    AST_WINDOW_SW: assert property (
        $changed(watchdog_window) && watchdog_window == CFG_WIN_12P5
        |-> $past(reg_wr) && $past(reg_addr) == CFG_ADDR_WDT_WIN)
        else $error("narrow window not from software");
endmodule
bind cfg_loader cfg_loader_chk #(.PART_ID(PART_ID), .STEP_ID(STEP_ID)) u_cfg_loader_chk (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
    .watchdog_prescale_setting(watchdog_prescale_setting),
    .watchdog_ratio_log2(watchdog_ratio_log2), .watchdog_sw_locked(watchdog_sw_locked),
    .watchdog_window(watchdog_window));
`default_nettype wire

/* File: tb/cfg_prog_host.sv */
// External programmer model on the program memory port
`timescale 1ns/100ps
`default_nettype none
module cfg_prog_host (
    // Clock
    input  wire logic        clk,
    // Programmer memory port
    output var logic         ext_wr,
    output var logic         ext_rd,
    output var logic [12:0]  ext_addr,
    output var logic [13:0]  ext_wdata,
    input  wire logic [13:0] ext_rdata
);
    initial begin
        {ext_wr, ext_rd, ext_addr, ext_wdata} = '0;
    end
    // Released lines show the inverse so stale values never pass
    task automatic pwrite(input logic [12:0] ad, input logic [13:0] dv);
        @(posedge clk);
        ext_addr <= ad;
        ext_wdata <= dv;
        ext_wr <= 1'b1;
        @(posedge clk);
        ext_wr <= 1'b0;
        ext_addr <= ~ad;
        ext_wdata <= ~dv;
    endtask
    task automatic pread(input logic [12:0] ad, output logic [13:0] dv);
        @(posedge clk);
        ext_addr <= ad;
        ext_rd <= 1'b1;
        @(posedge clk);
        ext_rd <= 1'b0;
        ext_addr <= ~ad;
        #1 dv = ext_rdata;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_cfg_loader.sv */
// Self-checking bench for the configuration decoder
`timescale 1ns/100ps
`default_nettype none
module tb_cfg_loader;
    import cfg_pkg::*;
    localparam logic [13:0] PID = 14'h1234; // Arbitrary value
    localparam logic [13:0] SID = 14'h0001; // Arbitrary value
    logic        clk, rst, reg_wr, reg_rd, ext_wr, ext_rd, cpu_wr, cpu_rd, lk;
    logic [15:0] reg_addr;
    logic [13:0] reg_wdata, reg_rdata, ext_wdata, ext_rdata, cpu_wdata, cpu_rdata, got;
    logic [12:0] ext_addr, cpu_addr;
    logic [4:0]  ps, lg;
    logic [2:0]  win;
    int          bad_count, num_checks, seed, pscale, a, d;
    int          uid[4];
    cfg_loader #(.PART_ID(PID), .STEP_ID(SID), .PM_DEPTH(64)) u_cfg_loader (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_wr(ext_wr),
        .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .watchdog_prescale_setting(ps), .watchdog_ratio_log2(lg),
        .watchdog_sw_locked(lk), .watchdog_window(win));
    cfg_prog_host u_cfg_prog_host (.clk(clk), .ext_wr(ext_wr), .ext_rd(ext_rd),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rw(input logic [15:0] ad, input logic [13:0] dv);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dv;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rr(input logic [15:0] ad, input logic [13:0] ev);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, ev);
    endtask
    task automatic cw(input logic [12:0] ad, input logic [13:0] dv);
        @(posedge clk);
        cpu_addr <= ad;
        cpu_wdata <= dv;
        cpu_wr <= 1'b1;
        @(posedge clk);
        cpu_wr <= 1'b0;
        #1;
    endtask
    task automatic cr(input logic [12:0] ad, input logic [13:0] ev);
        @(posedge clk);
        cpu_addr <= ad;
        cpu_rd <= 1'b1;
        @(posedge clk);
        cpu_rd <= 1'b0;
        #1 chk(cpu_rdata, ev);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, cpu_wr, cpu_rd, reg_addr, reg_wdata, cpu_addr, cpu_wdata} = '0;
        bad_count = 0;
        num_checks = 0;
        seed = 59445;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(14'(ps), 14'(CFG_PSEL_SW_DEF));
        chk(14'(win), 14'(CFG_WIN_FULL));
        rr(CFG_ADDR_PART, PID);
        rr(CFG_ADDR_STEP, SID);
        rw(CFG_ADDR_PART, 14'($random(seed)));
        rw(CFG_ADDR_STEP, 14'($random(seed)));
        rr(CFG_ADDR_PART, PID);
        rr(CFG_ADDR_STEP, SID);
        rr(16'h8004, 14'h0000);
        for (int i = 0; i < 4; i++) begin
            uid[i] = $random(seed) & 32'h3FFF;
            rw(CFG_ADDR_UID0 + 16'(i), 14'(uid[i]));
        end
        for (int i = 0; i < 4; i++) rr(CFG_ADDR_UID0 + 16'(i), 14'(uid[i]));
        pscale = $random(seed) & 32'h1F;
        rw(CFG_ADDR_WDT_PS, 14'(pscale));
        rr(CFG_ADDR_WDT_PS, 14'(pscale));
        // Every period code, each followed by a prescale write attempt
        for (int c = 0; c < 32; c++) begin
            rw(CFG_ADDR_CONF3, 14'h3FE0 | 14'(c));
            rw(CFG_ADDR_WDT_PS, 14'(c ^ 1));
            pscale = (c == 31) ? (c ^ 1) : pscale;
            chk(14'(lg), 14'((c == 31) ? 16 : (c > 18) ? 5 : 5 + c));
            chk(14'(lk), 14'(c != 31));
            chk(14'(ps), 14'(pscale));
        end
        rw(CFG_ADDR_WDT_WIN, 14'(CFG_WIN_12P5));
        chk(14'(win), 14'(CFG_WIN_12P5));
        a = 40 + ($random(seed) & 7);
        d = $random(seed) & 32'h3FFF;
        u_cfg_prog_host.pwrite(13'(a), 14'(d));
        u_cfg_prog_host.pread(13'(a), got);
        chk(got, 14'(d));
        cw(13'h0010, 14'h2AAA);
        rw(CFG_ADDR_CONF1, 14'h3F7F);
        u_cfg_prog_host.pread(13'(a), got);
        chk(got, 14'h0000);
        u_cfg_prog_host.pwrite(13'(a), ~14'(d));
        cr(13'(a), 14'(d));
        // Boot block guarded; 0220h wraps onto a free word of the small array
        rw(CFG_ADDR_CONF2, 14'h3FFE);
        cw(13'h0010, 14'h1555);
        cr(13'h0010, 14'h2AAA);
        cw(13'h0220, 14'h1555);
        cr(13'h0220, 14'h1555);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(14'(ps), 14'(CFG_PSEL_SW_DEF));
        chk(14'(lk), 14'h0000);
        rr(CFG_ADDR_UID0, CFG_UID_RESET);
        close_out();
    end
endmodule
`default_nettype wire
